// ### include/sso_pkg.sv
// constants and types for the servo status output selector
package sso_pkg;

   // selection codes shared by both status outputs
   localparam logic [3:0] SEL_TORQUE_LIMIT = 4'h0;
   localparam logic [3:0] SEL_ZERO_SPEED   = 4'h1;
   localparam logic [3:0] SEL_ANY_WARNING  = 4'h2;
   localparam logic [3:0] SEL_REGEN_WARN   = 4'h3;
   localparam logic [3:0] SEL_OVERLOAD     = 4'h4;
   localparam logic [3:0] SEL_BATTERY      = 4'h5;
   localparam logic [3:0] SEL_FAN_STALL    = 4'h6;
   localparam logic [3:0] SEL_EXT_SCALE    = 4'h7;
   localparam logic [3:0] SEL_IN_SPEED     = 4'h8;

   // reset values of the two selection settings
   localparam logic [3:0] FIRST_SEL_RST  = SEL_TORQUE_LIMIT;
   localparam logic [3:0] SECOND_SEL_RST = SEL_ZERO_SPEED;

   // warning thresholds in percent of trip level
   localparam int WARN_PERCENT = 85;
   localparam int PERCENT_FULL = 100;

   // fan stall time and clock
   localparam int  CLK_FREQ_HZ   = 100_000_000;
   localparam int  FAN_STALL_MS  = 1000;
   localparam int  FAN_STALL_CYC = (CLK_FREQ_HZ / 1000) * FAN_STALL_MS + 1;

   // control modes
   typedef enum logic [1:0] {
      SSO_MODE_POSITION = 2'h0,
      SSO_MODE_VELOCITY = 2'h1,
      SSO_MODE_TORQUE   = 2'h3,
      SSO_MODE_FULL_CL  = 2'h2
   } sso_mode_t;

endpackage

// ### hdl/sso_fan_timer.sv
// fan stall qualifier: stall must persist beyond a fixed time
`timescale 1ns/1ps
module sso_fan_timer #(
   parameter int STALL_CYC = 100_000_001
) (
   input  wire logic I_CLK_SYS,
   input  wire logic I_RST_N,
   input  wire logic i_stall,
   output logic      o_warn
);
   import sso_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic        warn;
   } sso_fan_st_t;

   sso_fan_st_t st_r;
   sso_fan_st_t st_nxt;

   // count continuous stall, restart on any release
   always_comb begin
      st_nxt = st_r;
      if (!i_stall) begin
         st_nxt.cnt  = '0;
         st_nxt.warn = 1'b0;
      end else if (st_r.cnt >= 32'(STALL_CYC - 1)) begin
         st_nxt.warn = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end

   // state register
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_warn = st_r.warn;
endmodule // sso_fan_timer

// ### hdl/sso_out_mux.sv
// one status output: code decode, codes above the table forced low
`timescale 1ns/1ps
module sso_out_mux (
   input  wire logic [3:0] i_sel,
   input  wire logic [8:0] i_cond,
   output logic            o_out
);
   import sso_pkg::*;

   // codes above the table give a low output
   always_comb begin
      if (i_sel <= SEL_IN_SPEED) begin
         o_out = i_cond[i_sel];
      end else begin
         o_out = 1'b0;
      end
   end
endmodule // sso_out_mux

// ### hdl/sso_status_select.sv
// top: servo status output selector for two digital outputs
`timescale 1ns/1ps
// ***************************************************************
// ***************************************************************
module sso_status_select #(
   parameter int SPD_W     = 16,
   parameter int LVL_W     = 16,
   parameter int STALL_CYC = sso_pkg::FAN_STALL_CYC
) (
   input  wire logic                I_CLK_SYS,
   input  wire logic                I_RST_N,
   input  wire logic                i_sel_load,
   input  wire logic [3:0]          i_first_status_select,
   input  wire logic [3:0]          i_second_status_select,
   input  wire sso_pkg::sso_mode_t  i_control_mode,
   input  wire logic                i_servo_on,
   input  wire logic                i_torque_clipped,
   input  wire logic [SPD_W-1:0]    i_motor_speed_abs,
   input  wire logic signed [SPD_W:0] i_speed_error,
   input  wire logic [SPD_W-1:0]    i_speed_window_setting,
   input  wire logic [LVL_W-1:0]    i_regen_level,
   input  wire logic [LVL_W-1:0]    i_regen_trip,
   input  wire logic [LVL_W-1:0]    i_load_level,
   input  wire logic [LVL_W-1:0]    i_load_trip,
   input  wire logic                i_battery_low,
   input  wire logic                i_fan_stalled,
   input  wire logic                i_scale_over_temp,
   input  wire logic                i_scale_weak_signal,
   output logic [3:0]               o_first_status_select,
   output logic [3:0]               o_second_status_select,
   output logic [8:0]               o_conditions,
   output logic                     o_torque_limit_status_out,
   output logic                     o_zero_speed_status_out
);
   import sso_pkg::*;

   localparam int PW = LVL_W + 8;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [3:0] sel_first;
      logic [3:0] sel_second;
      logic [8:0] cond;
      logic       out_first;
      logic       out_second;
   } sso_st_t;

   sso_st_t    st_r;
   sso_st_t    st_nxt;
   logic       fan_warn;
   logic       regen_warn;
   logic       load_warn;
   logic       scale_warn;
   logic       zero_spd;
   logic       in_speed;
   logic       any_warn;
   logic       mux_first;
   logic       mux_second;
   logic [SPD_W:0] err_abs;

   // ***************************************************************
   // condition detection
   // ***************************************************************
   sso_fan_timer #(
      .STALL_CYC (STALL_CYC)
   ) u_fan (
      .I_CLK_SYS (I_CLK_SYS),
      .I_RST_N   (I_RST_N),
      .i_stall   (i_fan_stalled),
      .o_warn    (fan_warn)
   );

   // percent comparisons scaled to avoid division
   assign regen_warn = (PW'(i_regen_level) * PW'(PERCENT_FULL))
                     > (PW'(i_regen_trip) * PW'(WARN_PERCENT));
   assign load_warn  = (PW'(i_load_level) * PW'(PERCENT_FULL))
                     > (PW'(i_load_trip) * PW'(WARN_PERCENT));
   // scale alarm needs full-closed mode
   assign scale_warn = (i_scale_over_temp | i_scale_weak_signal)
                     & (i_control_mode == SSO_MODE_FULL_CL);
   assign any_warn   = regen_warn | load_warn | i_battery_low
                     | fan_warn | scale_warn;
   assign zero_spd   = i_motor_speed_abs < i_speed_window_setting;
   // magnitude of speed minus pre-ramp command
   assign err_abs    = i_speed_error[SPD_W] ? (SPD_W+1)'(-i_speed_error)
                                            : i_speed_error;
   assign in_speed   = (err_abs <= {1'b0, i_speed_window_setting})
                     & ((i_control_mode == SSO_MODE_VELOCITY)
                      | (i_control_mode == SSO_MODE_TORQUE));

   // ***************************************************************
   // output selection
   // ***************************************************************
   sso_out_mux u_mux_first (
      .i_sel  (st_r.sel_first),
      .i_cond (st_r.cond),
      .o_out  (mux_first)
   );

   sso_out_mux u_mux_second (
      .i_sel  (st_r.sel_second),
      .i_cond (st_r.cond),
      .o_out  (mux_second)
   );

   // next state: load selectors, register conditions and outputs
   always_comb begin
      st_nxt = st_r;
      if (i_sel_load) begin
         st_nxt.sel_first  = i_first_status_select;
         st_nxt.sel_second = i_second_status_select;
      end
      st_nxt.cond[SEL_TORQUE_LIMIT] = i_servo_on & i_torque_clipped;
      st_nxt.cond[SEL_ZERO_SPEED]   = zero_spd;
      st_nxt.cond[SEL_ANY_WARNING]  = any_warn;
      st_nxt.cond[SEL_REGEN_WARN]   = regen_warn;
      st_nxt.cond[SEL_OVERLOAD]     = load_warn;
      st_nxt.cond[SEL_BATTERY]      = i_battery_low;
      st_nxt.cond[SEL_FAN_STALL]    = fan_warn;
      st_nxt.cond[SEL_EXT_SCALE]    = scale_warn;
      st_nxt.cond[SEL_IN_SPEED]     = in_speed;
      st_nxt.out_first  = mux_first;
      st_nxt.out_second = mux_second;
   end

   // state register with documented selector defaults
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         st_r            <= '0;
         st_r.sel_first  <= FIRST_SEL_RST;
         st_r.sel_second <= SECOND_SEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_first_status_select     = st_r.sel_first;
   assign o_second_status_select    = st_r.sel_second;
   assign o_conditions              = st_r.cond;
   assign o_torque_limit_status_out = st_r.out_first;
   assign o_zero_speed_status_out   = st_r.out_second;
endmodule // sso_status_select

// ### verification/sso_status_select_assertions.sv
// checker on the status output selector ports
`timescale 1ns/1ps
module sso_status_select_assertions (
   input wire logic               I_CLK_SYS,
   input wire logic               I_RST_N,
   input wire logic               i_sel_load,
   input wire logic [3:0]         i_first_status_select,
   input wire logic [3:0]         i_second_status_select,
   input wire sso_pkg::sso_mode_t i_control_mode,
   input wire logic [3:0]         o_first_status_select,
   input wire logic [3:0]         o_second_status_select,
   input wire logic [8:0]         o_conditions,
   input wire logic               o_torque_limit_status_out,
   input wire logic               o_zero_speed_status_out
);
   import sso_pkg::*;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   AST_LOAD: assert property (i_sel_load |=>
      o_first_status_select == $past(i_first_status_select)
      && o_second_status_select == $past(i_second_status_select))
      else $error("selector not loaded");
   AST_HOLD: assert property (!i_sel_load |=>
      $stable(o_first_status_select) && $stable(o_second_status_select))
      else $error("selector moved");
   AST_RST: assert property ($rose(I_RST_N) |->
      o_first_status_select == FIRST_SEL_RST
      && o_second_status_select == SECOND_SEL_RST)
      else $error("bad selector default");
   AST_MAP1: assert property (o_first_status_select < 4'h9 |=>
      o_torque_limit_status_out == $past(o_conditions[o_first_status_select]))
      else $error("first output mismatch");
   AST_MAP2: assert property (o_second_status_select < 4'h9 |=>
      o_zero_speed_status_out == $past(o_conditions[o_second_status_select]))
      else $error("second output mismatch");
   AST_BAD1: assert property (o_first_status_select > 4'h8 |=>
      !o_torque_limit_status_out)
      else $error("first output on for bad code");
   AST_BAD2: assert property (o_second_status_select > 4'h8 |=>
      !o_zero_speed_status_out)
      else $error("second output on for bad code");
   AST_ANY: assert property (|o_conditions[7:3] |->
      o_conditions[2])
      else $error("summary warning missing");
   AST_ANY_SRC: assert property (o_conditions[2] |->
      |o_conditions[7:3])
      else $error("summary warning without a source");
   AST_SCALE_MODE: assert property (o_conditions[7] |->
      $past(i_control_mode) == SSO_MODE_FULL_CL)
      else $error("scale warning outside full-closed mode");
   AST_SPD_MODE: assert property (o_conditions[8] |->
      $past(i_control_mode) == SSO_MODE_VELOCITY
      || $past(i_control_mode) == SSO_MODE_TORQUE)
      else $error("in-speed outside velocity or torque mode");
endmodule // sso_status_select_assertions
bind sso_status_select sso_status_select_assertions u_chk (
   .I_CLK_SYS                 (I_CLK_SYS),
   .I_RST_N                   (I_RST_N),
   .i_sel_load                (i_sel_load),
   .i_first_status_select     (i_first_status_select),
   .i_second_status_select    (i_second_status_select),
   .i_control_mode            (i_control_mode),
   .o_first_status_select     (o_first_status_select),
   .o_second_status_select    (o_second_status_select),
   .o_conditions              (o_conditions),
   .o_torque_limit_status_out (o_torque_limit_status_out),
   .o_zero_speed_status_out   (o_zero_speed_status_out)
);

// ### verification/sso_host_model.sv
// host controller model: reads both status outputs
`timescale 1ns/1ps
module sso_host_model (
   input  wire logic       I_CLK_SYS,
   input  wire logic [1:0] i_status,
   output logic [1:0]      o_seen
);
   // latch what the host reads each clock
   always_ff @(posedge I_CLK_SYS) o_seen <= i_status;
endmodule // sso_host_model

// ### verification/sso_status_select_test.sv
// self-checking bench for the status output selector
`timescale 1ns/1ps
module sso_status_select_test;
   import sso_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, sl = 1'b0;
   logic [3:0] sel = 4'h0, sel2 = 4'h0, f1, f2;
   logic [5:0] fl = 6'h00;
   logic [23:0] lv = 24'h000000;
   logic [1:0] outs, seen;
   logic signed [16:0] err;
   sso_mode_t md = SSO_MODE_POSITION;
   int err_total = 0, n_tests = 0, cyc = 0;
   // speed error against a fixed command of ten
   assign err = {9'h000, lv[23:16]} - 17'h0000a;
   sso_status_select #(.STALL_CYC(10)) DUT (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .i_sel_load(sl),
      .i_first_status_select(sel), .i_second_status_select(sel2),
      .i_control_mode(md), .i_servo_on(fl[5]), .i_torque_clipped(fl[4]),
      .i_motor_speed_abs({8'h00, lv[23:16]}), .i_speed_error(err),
      .i_speed_window_setting(16'h0005), .i_regen_trip(16'h0064),
      .i_regen_level({8'h00, lv[15:8]}), .i_load_trip(16'h0064),
      .i_load_level({8'h00, lv[7:0]}), .i_battery_low(fl[3]),
      .i_fan_stalled(fl[2]), .i_scale_over_temp(fl[1]),
      .i_scale_weak_signal(fl[0]), .o_first_status_select(f1),
      .o_second_status_select(f2), .o_conditions(),
      .o_torque_limit_status_out(outs[1]),
      .o_zero_speed_status_out(outs[0]));
   sso_host_model u_host (.I_CLK_SYS(clk), .i_status(outs), .o_seen(seen));
   always #5 clk = ~clk;
   task cmp(input string n, input logic [3:0] e, input logic [3:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk(input logic [3:0] c, input logic [1:0] m, input logic [5:0] f,
            input logic [23:0] w, input logic e);
      @(posedge clk);
      sel <= c;
      sel2 <= c;
      md <= sso_mode_t'(m);
      fl <= f;
      lv <= w;
      sl <= 1'b1;
      @(posedge clk);
      sl <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cmp("outputs", {2'h0, e, e}, {2'h0, seen});
   endtask
   // distinct codes on the two outputs: servo clipped, speed not zero
   task chk_pair(input logic [3:0] c1, input logic [3:0] c2,
                 input logic [1:0] e);
      @(posedge clk);
      sel <= c1;
      sel2 <= c2;
      fl <= 6'h30;
      lv <= 24'h090000;
      sl <= 1'b1;
      @(posedge clk);
      sl <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cmp("output pair", {2'h0, e}, {2'h0, seen});
      cmp("first select", c1, f1);
      cmp("second select", c2, f2);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 600) begin
         err_total++;
         complete_run;
      end
   end
   // mode codes: 0 position, 1 velocity, 3 torque, 2 full-closed
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      cmp("first select", FIRST_SEL_RST, f1);
      cmp("second select", SECOND_SEL_RST, f2);
      chk(4'h0, 2'h0, 6'h30, 24'h000000, 1'b1);
      chk(4'h0, 2'h0, 6'h10, 24'h000000, 1'b0);
      chk(4'h1, 2'h1, 6'h00, 24'h050000, 1'b0);
      chk(4'h1, 2'h1, 6'h00, 24'h040000, 1'b1);
      chk(4'h8, 2'h1, 6'h00, 24'h050000, 1'b1);
      chk(4'h8, 2'h3, 6'h00, 24'h0f0000, 1'b1);
      chk(4'h8, 2'h0, 6'h00, 24'h0f0000, 1'b0);
      chk(4'h3, 2'h0, 6'h00, 24'h005500, 1'b0);
      chk(4'h3, 2'h0, 6'h00, 24'h005600, 1'b1);
      chk(4'h4, 2'h0, 6'h00, 24'h000056, 1'b1);
      chk(4'h5, 2'h0, 6'h08, 24'h000000, 1'b1);
      chk(4'h2, 2'h0, 6'h08, 24'h000000, 1'b1);
      chk(4'h2, 2'h0, 6'h02, 24'h000000, 1'b0);
      chk(4'h2, 2'h2, 6'h02, 24'h000000, 1'b1);
      chk(4'h2, 2'h0, 6'h00, 24'h005600, 1'b1);
      chk(4'h9, 2'h0, 6'h3b, 24'h005656, 1'b0);
      chk(4'h6, 2'h0, 6'h04, 24'h000000, 1'b0);
      repeat (10) @(posedge clk);
      chk(4'h6, 2'h0, 6'h04, 24'h000000, 1'b1);
      chk(4'h7, 2'h0, 6'h02, 24'h000000, 1'b0);
      chk(4'h7, 2'h2, 6'h01, 24'h000000, 1'b1);
      chk(4'h7, 2'h2, 6'h02, 24'h000000, 1'b1);
      chk_pair(SEL_TORQUE_LIMIT, SEL_ZERO_SPEED, 2'h2);
      chk_pair(SEL_ZERO_SPEED, SEL_TORQUE_LIMIT, 2'h1);
      complete_run;
   end
endmodule // sso_status_select_test
